// ===== core/spc_port_ctrl.v
// Port 2 control bank: three registers plus the per-frame decisions they steer.
// Assumes frame descriptors and link status come from logic on clock_in.
//
// The Avalon-MM interface to the registers is this design's own decision.
`include "spc_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module spc_port_ctrl #(
  parameter LEN_W = 11
) (
  // Clock and reset
  input  wire              clock_in,
  input  wire              rst_in,
  // Avalon-MM slave
  input  wire [12:0]       avs_address_in,
  input  wire              avs_read_in,
  input  wire              avs_write_in,
  input  wire [3:0]        avs_byteenable_in,
  input  wire [31:0]       avs_writedata_in,
  output wire              avs_waitrequest_out,
  output wire [31:0]       avs_readdata_out,
  // Ingress frame descriptor
  input  wire              rx_frame_valid_in,
  input  wire              rx_tagged_in,
  input  wire [11:0]       rx_vid_in,
  input  wire [2:0]        rx_pri_in,
  input  wire [1:0]        rx_queue_in,
  input  wire [2:0]        rx_vlan_members_in,
  input  wire [2:0]        rx_dest_mask_in,
  input  wire              rx_bcast_in,
  input  wire              rx_mcast_in,
  input  wire              rx_flood_in,
  input  wire [LEN_W-1:0]  rx_len_in,
  input  wire [3:0]        rx_rate_reached_in,
  // Egress frame descriptor
  input  wire              tx_frame_valid_in,
  input  wire              tx_needs_tag_in,
  input  wire [LEN_W-1:0]  tx_len_in,
  // Link status
  input  wire              an_pause_in,
  input  wire              half_duplex_in,
  // Ingress decision
  output reg               rx_done_out,
  output reg               rx_drop_out,
  output reg  [2:0]        rx_fwd_mask_out,
  output reg  [11:0]       rx_vid_out,
  output reg  [2:0]        rx_pri_out,
  output reg               rx_monitor_out,
  output reg               rx_learn_out,
  output reg               rx_rate_count_out,
  output reg  [LEN_W:0]    rx_rate_bytes_out,
  // Egress decision
  output reg               tx_done_out,
  output reg               tx_insert_out,
  output reg  [15:0]       tx_tag_out,
  output reg               tx_monitor_out,
  output reg  [LEN_W:0]    tx_rate_bytes_out,
  // Port level controls
  output wire              tx_enable_out,
  output wire              flow_ctrl_out,
  output wire              backpressure_out,
  output wire              mirror_dest_out
);

  reg  [15:0] fwd_q;
  reg  [15:0] tag_q;
  reg  [15:0] rate_q;
  reg         ack_q;
  reg  [31:0] rdata_q;

  wire        req      = avs_read_in | avs_write_in;
  wire [10:0] idx      = avs_address_in[12:2];
  wire        hit_fwd  = (idx == `SPC_IDX_FWD);
  wire        hit_tag  = (idx == `SPC_IDX_TAG);
  wire        hit_rate = (idx == `SPC_IDX_RATE);
  wire        wr_go    = avs_write_in & ack_q;
  wire [15:0] be_mask  = {{8{avs_byteenable_in[1]}},
                          {8{avs_byteenable_in[0]}}};

  // One wait state per access; write lands on the edge that ends it
  assign avs_waitrequest_out = req & ~ack_q;
  assign avs_readdata_out    = rdata_q;

  // Merge write data into a register under byte lanes and writable mask
  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input [15:0] lanes;
    input [15:0] wmask;
    reg   [15:0] m;
    begin
      m     = lanes & wmask;
      merge = (old & ~m) | (wd & m);
    end
  endfunction

  always @(posedge clock_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always @(posedge clock_in) begin
    if (rst_in) begin
      fwd_q  <= `SPC_FWD_RESET;
      tag_q  <= `SPC_TAG_RESET;
      rate_q <= `SPC_RATE_RESET;
    end else if (wr_go) begin
      if (hit_fwd) begin
        fwd_q <= merge(fwd_q, avs_writedata_in[15:0], be_mask,
                       `SPC_FWD_WMASK);
      end
      if (hit_tag) begin
        tag_q <= merge(tag_q, avs_writedata_in[15:0], be_mask,
                       `SPC_TAG_WMASK);
      end
      if (hit_rate) begin
        rate_q <= merge(rate_q, avs_writedata_in[15:0], be_mask,
                        `SPC_RATE_WMASK);
      end
    end
  end

  // Read data captured in the wait cycle; unmapped words read zero
  always @(posedge clock_in) begin
    if (rst_in) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read_in & ~ack_q) begin
      if (hit_fwd) begin
        rdata_q <= {16'h0000, fwd_q & `SPC_FWD_WMASK};
      end else if (hit_tag) begin
        rdata_q <= {16'h0000, tag_q};
      end else if (hit_rate) begin
        rdata_q <= {16'h0000, rate_q & `SPC_RATE_WMASK};
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end

  // Field views
  wire        vlan_filt = fwd_q[`SPC_B_VLAN_FILT];
  wire        disc_npv  = fwd_q[`SPC_B_DISC_NPVID];
  wire        rx_en     = fwd_q[`SPC_B_RX_EN];
  wire        learn_dis = fwd_q[`SPC_B_LEARN_DIS];
  wire        rx_mirr   = fwd_q[`SPC_B_RX_MIRR];
  wire        tx_mirr   = fwd_q[`SPC_B_TX_MIRR];
  wire        pri_ceil  = fwd_q[`SPC_B_PRI_CEIL];
  wire [2:0]  members   = fwd_q[`SPC_F_MEMB];
  wire [2:0]  upri      = tag_q[`SPC_F_UPRI];
  wire [11:0] dflt_vid  = tag_q[`SPC_F_VID];
  wire [1:0]  lim_mode  = rate_q[`SPC_F_LIM_MODE];
  wire        cnt_ifg   = rate_q[`SPC_B_CNT_IFG];
  wire        cnt_pre   = rate_q[`SPC_B_CNT_PRE];

  assign tx_enable_out    = fwd_q[`SPC_B_TX_EN];
  assign flow_ctrl_out    = fwd_q[`SPC_B_FORCE_FC] | an_pause_in;
  assign backpressure_out = fwd_q[`SPC_B_BP_EN] & half_duplex_in;
  assign mirror_dest_out  = fwd_q[`SPC_B_MIRR_DST];

  // Overhead bytes added to every frame length for rate metering
  // Summed at full width, then cut to the byte count width on purpose
  wire [31:0]    ovh_sum =
    (cnt_ifg ? `SPC_IFG_BYTES : 32'h00000000) +
    (cnt_pre ? `SPC_PRE_BYTES : 32'h00000000);
  wire [LEN_W:0] ovh = ovh_sum[LEN_W:0];

  // Ingress classification
  wire        null_vid = ~rx_tagged_in | (rx_vid_in == 12'h000);
  wire [11:0] eff_vid  = null_vid ? dflt_vid : rx_vid_in;
  wire [2:0]  eff_pri  = (pri_ceil & (rx_pri_in > upri)) ?
                         upri : rx_pri_in;
  reg         limited;

  always @* begin
    limited = 1'b1;
    case (lim_mode)
      `SPC_MODE_ALL: limited = 1'b1;
      `SPC_MODE_BMF: limited = rx_bcast_in | rx_mcast_in | rx_flood_in;
      `SPC_MODE_BM:  limited = rx_bcast_in | rx_mcast_in;
      `SPC_MODE_B:   limited = rx_bcast_in;
      default:       limited = 1'b1;
    endcase
  end

  wire drop_filt = vlan_filt & ~rx_vlan_members_in[`SPC_MEMB_SELF];
  wire drop_npv  = disc_npv & (eff_vid != dflt_vid);
  wire drop_rate = limited & rx_rate_reached_in[rx_queue_in];
  wire drop_all  = ~rx_en | drop_filt | drop_npv | drop_rate;

  always @(posedge clock_in) begin
    if (rst_in) begin
      rx_done_out       <= 1'b0;
      rx_drop_out       <= 1'b0;
      rx_fwd_mask_out   <= 3'h0;
      rx_vid_out        <= 12'h000;
      rx_pri_out        <= 3'h0;
      rx_monitor_out    <= 1'b0;
      rx_learn_out      <= 1'b0;
      rx_rate_count_out <= 1'b0;
      rx_rate_bytes_out <= {(LEN_W+1){1'b0}};
    end else begin
      rx_done_out <= rx_frame_valid_in;
      if (rx_frame_valid_in) begin
        rx_drop_out       <= drop_all;
        rx_fwd_mask_out   <= drop_all ? 3'h0 :
                             (rx_dest_mask_in & members);
        rx_vid_out        <= eff_vid;
        rx_pri_out        <= eff_pri;
        rx_monitor_out    <= rx_mirr & ~drop_all;
        rx_learn_out      <= ~learn_dis & rx_en;
        rx_rate_count_out <= limited & rx_en;
        rx_rate_bytes_out <= {1'b0, rx_len_in} + ovh;
      end
    end
  end

  // Egress: tagging, mirroring and rate byte count
  always @(posedge clock_in) begin
    if (rst_in) begin
      tx_done_out       <= 1'b0;
      tx_insert_out     <= 1'b0;
      tx_tag_out        <= 16'h0000;
      tx_monitor_out    <= 1'b0;
      tx_rate_bytes_out <= {(LEN_W+1){1'b0}};
    end else begin
      tx_done_out <= tx_frame_valid_in & tx_enable_out;
      if (tx_frame_valid_in) begin
        tx_insert_out     <= tx_needs_tag_in & tx_enable_out;
        tx_tag_out        <= tag_q;
        tx_monitor_out    <= tx_mirr & tx_enable_out;
        tx_rate_bytes_out <= {1'b0, tx_len_in} + ovh;
      end
    end
  end

endmodule

`default_nettype wire

// ===== core/spc_regs.vh
// Port 2 control register bank: register indices, field positions, resets.
// Assumes a 32-bit Avalon-MM slave, one word per register index.
// How it works
// - Ingress VLAN filtering drops frames whose VLAN members exclude port 2
// - Discard-non-default-VID drops frames whose VID differs from default VID
// - Force flow control enables pause regardless of negotiated result
// - Half-duplex backpressure applied only while its enable is set
// - Transmit allowed only while transmit enable is set; resets to 1
// - Received frames accepted only while receive enable set; resets to 1
// - Learning-disable set stops source address learning
// - Mirror-destination makes this port transmit the monitored frames
// - Receive mirroring marks every received frame that is not dropped as monitored, copied out
// - Transmit mirroring marks every transmitted frame monitored, copied out
// - Priority ceiling clamps frame priority to default-tag user priority
// - Membership bit2 host, bit1 port 2, bit0 port 1; resets to 111
// - Default tag bits 15..13 hold user priority, reset zero
// - Default tag bit 12 holds CFI, reset zero
// - Default tag bits 11..0 hold default VID, reset one
// - Untagged or null-VID frames take the default VID for lookup
// - Egress tag insertion uses default tag register contents
// - Limit mode: 00 all, 01 bc/mc/flood, 10 bc/mc, 11 bc only
// - Gap counting adds 12 bytes per frame to rate calculations
// - Preamble counting adds 8 bytes per frame to rate calculations
// - Inserted egress tag carries this port's own default tag register, not the ingress port's
// - Frames the limit mode covers are discarded once their queue's rate is reached
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

`define SPC_IDX_FWD      11'h522
`define SPC_IDX_TAG      11'h524
`define SPC_IDX_RATE     11'h526

`define SPC_FWD_RESET    16'h0607
`define SPC_FWD_WMASK    16'h7FEF
`define SPC_TAG_RESET    16'h0001
`define SPC_TAG_WMASK    16'hFFFF
`define SPC_RATE_RESET   16'h0000
`define SPC_RATE_WMASK   16'h000F

`define SPC_B_VLAN_FILT  14
`define SPC_B_DISC_NPVID 13
`define SPC_B_FORCE_FC   12
`define SPC_B_BP_EN      11
`define SPC_B_TX_EN      10
`define SPC_B_RX_EN      9
`define SPC_B_LEARN_DIS  8
`define SPC_B_MIRR_DST   7
`define SPC_B_RX_MIRR    6
`define SPC_B_TX_MIRR    5
`define SPC_B_PRI_CEIL   3
`define SPC_F_MEMB       2:0
`define SPC_F_UPRI       15:13
`define SPC_B_CFI        12
`define SPC_F_VID        11:0
`define SPC_F_LIM_MODE   3:2
`define SPC_B_CNT_IFG    1
`define SPC_B_CNT_PRE    0

`define SPC_MODE_ALL     2'h0
`define SPC_MODE_BMF     2'h1
`define SPC_MODE_BM      2'h2
`define SPC_MODE_B       2'h3

`define SPC_IFG_BYTES    32'h0000000C
`define SPC_PRE_BYTES    32'h00000008
`define SPC_MEMB_SELF    1

`endif

// ===== sim/spc_port_ctrl_properties.sv
// Checker: frame decisions and port levels of the port 2 control bank.
// Bound to spc_port_ctrl; one clock, synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module spc_port_ctrl_properties #(parameter LEN_W = 11) (
  // Clock, reset and inputs
  input wire logic             clock_in, rst_in,
  input wire logic             rx_frame_valid_in, tx_frame_valid_in,
  input wire logic [2:0]       rx_pri_in, rx_dest_mask_in,
  input wire logic [LEN_W-1:0] tx_len_in,
  input wire logic             an_pause_in, half_duplex_in,
  // Design outputs
  input wire logic             rx_done_out, rx_drop_out, tx_done_out,
  input wire logic [2:0]       rx_fwd_mask_out, rx_pri_out,
  input wire logic [LEN_W:0]   tx_rate_bytes_out,
  input wire logic             tx_enable_out, flow_ctrl_out,
  input wire logic             backpressure_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_rx_taken;
    rx_frame_valid_in;
  endsequence
  sequence s_tx_done;
    tx_frame_valid_in ##1 tx_done_out;
  endsequence
  chk_rx_answer: assert property (s_rx_taken |=> rx_done_out)
    else $error("ingress frame got no decision");
  chk_tx_gate: assert property (
    tx_frame_valid_in |=> tx_done_out == $past(tx_enable_out))
    else $error("transmit done disagrees with transmit enable");
  chk_flow_force: assert property (an_pause_in |-> flow_ctrl_out)
    else $error("flow control off despite negotiated pause");
  chk_bp_duplex: assert property (backpressure_out |-> half_duplex_in)
    else $error("backpressure on a full duplex link");
  chk_drop_quiet: assert property (
    rx_done_out && rx_drop_out |-> rx_fwd_mask_out == 3'h0)
    else $error("dropped frame still forwarded");
  chk_fwd_member: assert property (
    s_rx_taken |=> (rx_fwd_mask_out & ~$past(rx_dest_mask_in)) == 3'h0)
    else $error("frame forwarded outside its destinations");
  chk_pri_ceiling: assert property (
    s_rx_taken |=> rx_pri_out <= $past(rx_pri_in))
    else $error("priority raised instead of clamped");
  chk_tx_overhead: assert property (s_tx_done |->
    (tx_rate_bytes_out - {1'b0, $past(tx_len_in)})
      inside {12'h000, 12'h008, 12'h00C, 12'h014})
    else $error("egress byte count has a bad overhead");
endmodule
bind spc_port_ctrl spc_port_ctrl_properties #(.LEN_W(LEN_W)) u_props (.*);
`default_nettype wire

// ===== sim/tb_top.sv
// Bench: register access and frame decisions of the port 2 control bank.
// Drives spc_port_ctrl directly; expectations come from bench functions.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0;
  logic rx_frame_valid_in = 0, rx_tagged_in = 0, rx_bcast_in = 0;
  logic rx_mcast_in = 0, rx_flood_in = 0, tx_frame_valid_in = 0;
  logic tx_needs_tag_in = 0, an_pause_in = 0, half_duplex_in = 0;
  logic [1:0] rx_queue_in = 0;
  logic [2:0] rx_pri_in = 0, rx_vlan_members_in = 0, rx_dest_mask_in = 0;
  logic [3:0] rx_rate_reached_in = 0, avs_byteenable_in = 4'hF;
  logic [10:0] rx_len_in = 0, tx_len_in = 0;
  logic [11:0] rx_vid_in = 0;
  logic [12:0] avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, x;
  logic [15:0] f, t, r;
  logic [33:0] e;
  int n_errors = 0, num_checks = 0;
  wire avs_waitrequest_out, rx_done_out, rx_drop_out, rx_monitor_out;
  wire rx_learn_out, rx_rate_count_out, tx_done_out, tx_insert_out;
  wire tx_monitor_out, tx_enable_out, flow_ctrl_out, backpressure_out;
  wire mirror_dest_out;
  wire [2:0] rx_fwd_mask_out, rx_pri_out;
  wire [11:0] rx_vid_out, rx_rate_bytes_out, tx_rate_bytes_out;
  wire [15:0] tx_tag_out;
  wire [31:0] avs_readdata_out;
  wire [33:0] rx_got = {rx_drop_out, rx_fwd_mask_out, rx_vid_out, rx_pri_out,
    rx_monitor_out, rx_learn_out, rx_rate_count_out, rx_rate_bytes_out};
  wire [29:0] tx_got = {tx_insert_out, tx_tag_out, tx_monitor_out,
    tx_rate_bytes_out};
  wire [3:0] lv = {tx_enable_out, flow_ctrl_out, backpressure_out,
    mirror_dest_out};
  // Forwarding, tag, rate-count, then an unmapped word
  logic [12:0] ad [4] = '{13'h1488, 13'h1490, 13'h1498, 13'h1FFC};
  logic [15:0] rv [4] = '{16'h0607, 16'h0001, 16'h0000, 16'h0000};
  logic [15:0] wm [4] = '{16'h7FEF, 16'hFFFF, 16'h000F, 16'h0000};
  spc_port_ctrl #(.LEN_W(11)) dut (.*);
  always #4 clock_in = ~clock_in;
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Request stands until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [12:0] a, input logic [15:0] d);
    @(posedge clock_in);
    {avs_write_in, avs_read_in} <= {w, !w};
    avs_address_in <= a;
    avs_writedata_in <= {16'h0000, d};
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clock_in);
    x = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'h0;
  endtask
  function automatic logic [11:0] ovh(input logic [15:0] c);
    return (c[1] ? 12'h00C : 12'h000) + (c[0] ? 12'h008 : 12'h000);
  endfunction
  function automatic logic [33:0] rx_exp();
    logic [11:0] v;
    logic lim, drop;
    v = (!rx_tagged_in || rx_vid_in == 12'h000) ? t[11:0] : rx_vid_in;
    case (r[3:2])
      2'h0: lim = 1'b1;
      2'h1: lim = rx_bcast_in | rx_mcast_in | rx_flood_in;
      2'h2: lim = rx_bcast_in | rx_mcast_in;
      default: lim = rx_bcast_in;
    endcase
    drop = !f[9] | (f[14] & !rx_vlan_members_in[1]) | (f[13] & v != t[11:0])
      | (lim & rx_rate_reached_in[rx_queue_in]);
    return {drop, drop ? 3'h0 : rx_dest_mask_in & f[2:0], v,
      (f[3] && rx_pri_in > t[15:13]) ? t[15:13] : rx_pri_in, !drop & f[6],
      !f[8] & f[9], lim & f[9], ovh(r) + {1'b0, rx_len_in}};
  endfunction
  initial begin
    void'($urandom(32'hAAED151E));
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    #1 chk(lv, 4'h8);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ad[i], 16'h0000);
      chk(x, rv[i]);
      bus(1'b1, ad[i], 16'hFFFF);
      bus(1'b0, ad[i], 16'h0000);
      chk(x, wm[i]);
    end
    for (int i = 0; i < 60; i++) begin
      {f, t, r} = {16'($urandom), 16'($urandom), 16'($urandom)};
      bus(1'b1, ad[0], f);
      bus(1'b1, ad[1], t);
      bus(1'b1, ad[2], r);
      bus(1'b0, ad[0], 16'h0000);
      chk(x, f & 16'h7FEF);
      @(posedge clock_in);
      {rx_tagged_in, rx_bcast_in, rx_mcast_in, rx_flood_in, an_pause_in,
        half_duplex_in, tx_needs_tag_in, rx_pri_in, rx_vlan_members_in,
        rx_queue_in, rx_rate_reached_in} <= 19'($urandom);
      rx_dest_mask_in <= 3'($urandom) & 3'h5;
      rx_vid_in <= (i % 3 == 0) ? t[11:0] :
        (i % 3 == 1) ? 12'h000 : 12'($urandom);
      {rx_len_in, tx_len_in} <= 22'($urandom);
      {rx_frame_valid_in, tx_frame_valid_in} <= 2'h3;
      @(posedge clock_in);
      {rx_frame_valid_in, tx_frame_valid_in} <= 2'h0;
      #1 e = rx_exp();
      chk(rx_done_out, 1'b1);
      chk(rx_got[33:18], e[33:18]);
      chk(rx_got[17:12], e[17:12]);
      chk(rx_got[11:0], e[11:0]);
      chk(tx_done_out, f[10]);
      e[29:0] = {tx_needs_tag_in, t, f[5], ovh(r) + {1'b0, tx_len_in}};
      if (f[10]) chk(tx_got, e[29:0]);
      e[3:0] = {f[10], f[12] | an_pause_in, f[11] & half_duplex_in, f[7]};
      chk(lv, e[3:0]);
      @(posedge clock_in);
      #1 chk({rx_done_out, tx_done_out}, 2'h0);
    end
    // Mid-run reset: every register and decision returns to its reset value
    @(posedge clock_in);
    rst_in <= 1'b1;
    @(posedge clock_in);
    #1 chk({rx_got, tx_got}, 64'h0);
    chk(lv, {1'b1, an_pause_in, 2'h0});
    @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ad[i], 16'h0000);
      chk(x, rv[i]);
    end
    // Only the low byte lane is written
    avs_byteenable_in <= 4'h1;
    bus(1'b1, ad[1], 16'hABCD);
    avs_byteenable_in <= 4'hF;
    bus(1'b0, ad[1], 16'h0000);
    chk(x, 16'h00CD);
    report_and_stop();
  end
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
